// File: design/clock_sources_regs.svh
`ifndef CLOCK_SOURCES_REGS_SVH
`define CLOCK_SOURCES_REGS_SVH

// register byte offsets
`define CS_CTC_CTRL_OFS    8'h00
`define CS_CTC_COUNT_OFS   8'h04
`define CS_FTW_CTRL_OFS    8'h08
`define CS_PLL_CTRL_OFS    8'h0c
`define CS_DBL_CTRL_OFS    8'h10
`define CS_OSC_CTRL_OFS    8'h14
`define CS_DIV_BASE_OFS    8'h40
`define CS_DIV_COUNT       13

// ctc_ctrl fields
`define CS_CTC_WAKE_EN_BIT 0
`define CS_CTC_IRQ_EN_BIT  1
`define CS_CTC_SEL_LSB     4
`define CS_CTC_RESET_BIT   31
// ftw_ctrl fields
`define CS_FTW_TC_LSB      0
`define CS_FTW_EN_BIT      8
`define CS_FTW_IRQ_EN_BIT  9
`define CS_FTW_CNT_LSB     16
// pll_ctrl fields
`define CS_PLL_EN_BIT      0
`define CS_PLL_REF_LSB     1
`define CS_PLL_P_LSB       8
`define CS_PLL_Q_LSB       16
`define CS_PLL_LOCK_BIT    31
`define CS_PLL_P_MIN       8'h04
// dbl_ctrl fields
`define CS_DBL_EN_BIT      0
`define CS_DBL_SRC_LSB     1
`define CS_DBL_READY_BIT   31
// osc_ctrl fields
`define CS_OSC_RANGE_LSB   0
`define CS_OSC_USB_BIT     3
`define CS_OSC_SYS_LSB     4
`define CS_MAIN_RANGE_MAX  3'h5
// div_cfg fields
`define CS_DIV_VAL_LSB     0
`define CS_DIV_SRC_LSB     16
`define CS_DIV_EN_BIT      31

// reset values
`define CS_CTC_CTRL_RST    32'h0000_00a0
`define CS_FTW_TC_RST      5'h1f
`define CS_PLL_P_RST       8'h08
`define CS_PLL_Q_RST       4'h0
`define CS_DIV_VAL_RST     16'h0002

// timing
`define CS_CLK_NS          10
`define CS_FLP_HALF_NS     5000
`define CS_FLP_HALF_CYC    (`CS_FLP_HALF_NS / `CS_CLK_NS)
`define CS_THIRD_HALVES    3
`define CS_SLOW_HALVES     100
`define CS_PLL_LOCK_US     250
`define CS_PLL_LOCK_CYC    (`CS_PLL_LOCK_US * 1000 / `CS_CLK_NS)
`define CS_DBL_START_US    1
`define CS_DBL_START_CYC   (`CS_DBL_START_US * 1000 / `CS_CLK_NS)
`define CS_RTC_EDGES       32768

`endif

// File: design/clock_sources_pkg.sv
package clock_sources_pkg;
	typedef enum logic [2:0] {
		SYS_MAIN  = 3'h0,
		SYS_PLL   = 3'h1,
		SYS_XTAL  = 3'h2,
		SYS_ROUTE = 3'h3,
		SYS_FLP   = 3'h4
	} sys_src_t;

	typedef enum logic [1:0] {
		REF_MAIN  = 2'h0,
		REF_XTAL  = 2'h1,
		REF_ROUTE = 2'h2
	} ref_src_t;

	typedef enum logic [2:0] {
		LK_OFF     = 3'b001,
		LK_WAIT    = 3'b010,
		LK_LOCKED  = 3'b100
	} lock_state_t;
endpackage

// File: design/clk_divider.sv
`timescale 1ns/1ps
// counts both edges of the chosen source so odd ratios still give 50% duty
module clk_divider (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// configuration
	input  wire logic        enable,
	input  wire logic [2:0]  src_sel,
	input  wire logic [15:0] divide,
	input  wire logic [7:0]  sources,
	// divided clock
	output logic             clk_out_ff
);
	logic        prev_ff;
	logic [2:0]  sel_ff;
	logic [15:0] cnt_ff;
	logic        cur;

	assign cur = sources[src_sel];

	// edge tracking; a source change restarts the count so no runt pulse escapes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev_ff <= 1'b0;
			sel_ff  <= 3'h0;
		end else begin
			prev_ff <= cur;
			sel_ff  <= src_sel;
		end
	end

	// half-period counter, divide below two is refused and holds the output low
	always_ff @(posedge aclk) begin
		if (!aresetn || !enable || divide < 16'h0002 || sel_ff != src_sel) begin
			cnt_ff     <= 16'h0000;
			clk_out_ff <= 1'b0;
		end else if (cur != prev_ff) begin
			if (cnt_ff == divide - 16'h0001) begin
				cnt_ff     <= 16'h0000;
				clk_out_ff <= ~clk_out_ff;
			end else begin
				cnt_ff <= cnt_ff + 16'h0001;
			end
		end
	end
endmodule

// File: design/clock_sources.sv
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "clock_sources_regs.svh"
// Summary of operation
// - 13-bit central tick counter advances once per slow tick clock period.
// - central tick counter holds during hibernate and during debug halt.
// - software write forces the central tick counter back to zero.
// - central counter gives periodic wake pulses and optional interrupt.
// - 5-bit fast tick counter advances on the fast low-power clock.
// - fast counter wraps to zero itself at its programmable terminal count.
// - fast counter raises interrupt at each terminal count when enabled.
// - low-speed section produces 1 kHz, 33 kHz and 100 kHz clocks.
// - 33 kHz clock is the 100 kHz clock divided by three.
// - fast low-power clock is selectable as system clock.
// - PLL locks within 250 us; lock is a readable status bit.
// - PLL reference chosen from main oscillator, crystal, or routed clock.
// - lock appears as routable signal, asserted only after lock completes.
// - PLL output 24-80 MHz, dividers give 4032 distinct ratios.
// - doubler makes 48 MHz for USB from a 24 MHz input.
// - doubler input chosen from main oscillator, crystal, or routed clock.
// - main oscillator has six ranges, each with its own stored trim.
// - divided outputs have 50 percent duty cycle.
// - eight digital, four analog, one bus divider, each own source select.
// - main oscillator offers a USB auto-lock mode.
// - watch crystal drives a once-per-second real-time interrupt.
// - each divider: eight-way mux, divide by two or more, resynchronised.
module clock_sources #(
	parameter int PLL_LOCK_CYC = `CS_PLL_LOCK_CYC,
	parameter int RTC_EDGES    = `CS_RTC_EDGES
) (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// axi4-lite read
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// asynchronous pins: power state, debug halt, watch crystal, divider sources
	input  wire logic        hibernate,
	input  wire logic        debug_halt,
	input  wire logic        watch_crystal_osc,
	input  wire logic [7:0]  div_sources,
	// low-speed clocks and timers
	output logic             fast_low_power_clock,
	output logic             third_rate_clock,
	output logic             slow_tick_clock,
	output logic             ctc_wake,
	output logic             ctc_irq,
	output logic             ftw_irq,
	output logic             rtc_irq,
	// oscillator, pll and doubler controls
	output logic [2:0]       osc_range,
	output logic [7:0]       osc_trim,
	output logic             osc_usb_mode,
	output logic [2:0]       sys_clk_sel,
	output logic             pll_enable,
	output logic [1:0]       pll_ref_sel,
	output logic [7:0]       pll_p,
	output logic [3:0]       pll_q,
	output logic             pll_lock,
	output logic             dbl_enable,
	output logic [1:0]       dbl_src_sel,
	output logic             dbl_ready,
	// divided clocks: 0-7 digital, 8-11 analog, 12 bus
	output logic [12:0]      div_clk
);
	localparam int NSYNC = 11;

	generate
		if (PLL_LOCK_CYC < 1 || PLL_LOCK_CYC > 65535 || RTC_EDGES < 2 || RTC_EDGES > 65536) begin
			$error("clock_sources: timing parameter out of range");
		end
	endgenerate

	// input synchronisers: three stages, a change counts when stages two and three agree
	logic [NSYNC-1:0] s1_ff, s2_ff, s3_ff, pin_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_ff  <= '0;
			s2_ff  <= '0;
			s3_ff  <= '0;
			pin_ff <= '0;
		end else begin
			s1_ff  <= {div_sources, watch_crystal_osc, debug_halt, hibernate};
			s2_ff  <= s1_ff;
			s3_ff  <= s2_ff;
			pin_ff <= (s2_ff & s3_ff) | (pin_ff & (s2_ff | s3_ff));
		end
	end
	wire logic hib_s   = pin_ff[0];
	wire logic halt_s  = pin_ff[1];
	wire logic watch_s = pin_ff[2];

	// ---------------- axi4-lite slave ----------------
	logic        aw_got_ff, w_got_ff;
	logic [7:0]  wa_ff;
	logic [31:0] wd_ff;
	logic [3:0]  ws_ff;
	logic        wr_fire;
	logic        wr_ok;
	logic [31:0] rd_val;
	logic        rd_ok;

	assign wr_fire = aw_got_ff && w_got_ff && !bvalid;

	// write channels are taken in either order; response only once both are held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_ff <= 1'b0;
			w_got_ff  <= 1'b0;
			awready   <= 1'b1;
			wready    <= 1'b1;
			bvalid    <= 1'b0;
			bresp     <= 2'h0;
			wa_ff     <= 8'h00;
			wd_ff     <= 32'h0000_0000;
			ws_ff     <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_got_ff <= 1'b1;
				awready   <= 1'b0;
				wa_ff     <= awaddr;
			end
			if (wvalid && wready) begin
				w_got_ff <= 1'b1;
				wready   <= 1'b0;
				wd_ff    <= wdata;
				ws_ff    <= wstrb;
			end
			if (wr_fire) begin
				aw_got_ff <= 1'b0;
				w_got_ff  <= 1'b0;
				bvalid    <= 1'b1;
				bresp     <= wr_ok ? 2'h0 : 2'h2;
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// read answers one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= 2'h0;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= rd_ok ? rd_val : 32'h0000_0000;
			rresp   <= rd_ok ? 2'h0 : 2'h2;
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic div_hit(input logic [7:0] a);
		return a[7:6] == 2'h1 && a[1:0] == 2'h0 && a[5:2] < 4'(`CS_DIV_COUNT);
	endfunction

	// ---------------- control registers ----------------
	logic [31:0] ctc_ctrl_ff, ftw_ctrl_ff, pll_ctrl_ff, dbl_ctrl_ff, osc_ctrl_ff;
	logic [31:0] div_cfg_ff [`CS_DIV_COUNT];
	logic [31:0] wv;
	logic [31:0] pll_wv, osc_wv;
	logic        ctc_clear;

	assign wr_ok = div_hit(wa_ff) || wa_ff == `CS_CTC_CTRL_OFS || wa_ff == `CS_FTW_CTRL_OFS
		|| wa_ff == `CS_PLL_CTRL_OFS || wa_ff == `CS_DBL_CTRL_OFS
		|| wa_ff == `CS_OSC_CTRL_OFS || wa_ff == `CS_CTC_COUNT_OFS;
	assign wv        = wd_ff;
	// merged words kept apart so their fields are range checked before they land
	assign pll_wv    = merge(pll_ctrl_ff, wv, ws_ff);
	assign osc_wv    = merge(osc_ctrl_ff, wv, ws_ff);
	assign ctc_clear = wr_fire && wa_ff == `CS_CTC_CTRL_OFS && ws_ff[3]
		&& wv[`CS_CTC_RESET_BIT];

	// configuration writes; illegal pll ratios and oscillator ranges are ignored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctc_ctrl_ff <= `CS_CTC_CTRL_RST;
			ftw_ctrl_ff <= {23'h0, 4'h0, `CS_FTW_TC_RST};
			pll_ctrl_ff <= {12'h0, `CS_PLL_Q_RST, `CS_PLL_P_RST, 8'h00};
			dbl_ctrl_ff <= 32'h0000_0000;
			osc_ctrl_ff <= 32'h0000_0000;
		end else if (wr_fire) begin
			case (wa_ff)
				`CS_CTC_CTRL_OFS: ctc_ctrl_ff <= merge(ctc_ctrl_ff, wv, ws_ff) & 32'h0000_00f3;
				`CS_FTW_CTRL_OFS: ftw_ctrl_ff <= merge(ftw_ctrl_ff, wv, ws_ff) & 32'h0000_031f;
				`CS_PLL_CTRL_OFS: begin
					if (pll_wv[`CS_PLL_P_LSB +: 8] >= `CS_PLL_P_MIN) begin
						pll_ctrl_ff <= pll_wv & 32'h000f_ff07;
					end
				end
				`CS_DBL_CTRL_OFS: dbl_ctrl_ff <= merge(dbl_ctrl_ff, wv, ws_ff) & 32'h0000_0007;
				`CS_OSC_CTRL_OFS: begin
					if (osc_wv[2:0] <= `CS_MAIN_RANGE_MAX
						&& osc_wv[6:4] <= 3'(clock_sources_pkg::SYS_FLP)) begin
						osc_ctrl_ff <= osc_wv & 32'h0000_007f;
					end
				end
				default: ;
			endcase
		end
	end

	// one config word per divider, each with its own source select
	genvar gi;
	generate
		for (gi = 0; gi < `CS_DIV_COUNT; gi++) begin : g_div
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					div_cfg_ff[gi] <= {16'h0000, `CS_DIV_VAL_RST};
				end else if (wr_fire && div_hit(wa_ff) && wa_ff[5:2] == 4'(gi)) begin
					div_cfg_ff[gi] <= merge(div_cfg_ff[gi], wv, ws_ff) & 32'h8007_ffff;
				end
			end
			clk_divider u_div (
				.aclk       (aclk),
				.aresetn    (aresetn),
				.enable     (div_cfg_ff[gi][`CS_DIV_EN_BIT]),
				.src_sel    (div_cfg_ff[gi][`CS_DIV_SRC_LSB +: 3]),
				.divide     (div_cfg_ff[gi][`CS_DIV_VAL_LSB +: 16]),
				.sources    (pin_ff[10:3]),
				.clk_out_ff (div_clk[gi])
			);
		end
	endgenerate

	// ---------------- low-speed clocks ----------------
	logic [9:0] flp_cnt_ff;
	logic [1:0] third_cnt_ff;
	logic [6:0] slow_cnt_ff;
	logic       flp_half, fast_tick, slow_tick;

	assign flp_half  = flp_cnt_ff == 10'(`CS_FLP_HALF_CYC - 1);
	assign fast_tick = flp_half && !fast_low_power_clock;
	assign slow_tick = flp_half && slow_cnt_ff == 7'(`CS_SLOW_HALVES - 1) && !slow_tick_clock;

	// all three clocks toggle on 100 kHz half periods, so the dividers stay at 50% duty
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flp_cnt_ff           <= 10'h000;
			third_cnt_ff         <= 2'h0;
			slow_cnt_ff          <= 7'h00;
			fast_low_power_clock <= 1'b0;
			third_rate_clock     <= 1'b0;
			slow_tick_clock      <= 1'b0;
		end else begin
			flp_cnt_ff <= flp_half ? 10'h000 : flp_cnt_ff + 10'h001;
			if (flp_half) begin
				fast_low_power_clock <= ~fast_low_power_clock;
				if (third_cnt_ff == 2'(`CS_THIRD_HALVES - 1)) begin
					third_cnt_ff     <= 2'h0;
					third_rate_clock <= ~third_rate_clock;
				end else begin
					third_cnt_ff <= third_cnt_ff + 2'h1;
				end
				if (slow_cnt_ff == 7'(`CS_SLOW_HALVES - 1)) begin
					slow_cnt_ff     <= 7'h00;
					slow_tick_clock <= ~slow_tick_clock;
				end else begin
					slow_cnt_ff <= slow_cnt_ff + 7'h01;
				end
			end
		end
	end

	// ---------------- central tick counter ----------------
	logic [12:0] ctc_cnt_ff, nxt_ctc;
	logic [12:0] ctc_mask;

	assign nxt_ctc  = ctc_cnt_ff + 13'h0001;
	assign ctc_mask = 13'((14'h0001 << ctc_ctrl_ff[`CS_CTC_SEL_LSB +: 4]) - 14'h0001);

	// wake pulses every 2^sel ticks, every 2^13 for sel 13 to 15; reset wins over a tick in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctc_cnt_ff <= 13'h0000;
			ctc_wake   <= 1'b0;
			ctc_irq    <= 1'b0;
		end else begin
			ctc_wake <= 1'b0;
			ctc_irq  <= 1'b0;
			if (ctc_clear) begin
				ctc_cnt_ff <= 13'h0000;
			end else if (slow_tick && !hib_s && !halt_s) begin
				ctc_cnt_ff <= nxt_ctc;
				if ((nxt_ctc & ctc_mask) == 13'h0000 && ctc_ctrl_ff[`CS_CTC_WAKE_EN_BIT]) begin
					ctc_wake <= 1'b1;
					ctc_irq  <= ctc_ctrl_ff[`CS_CTC_IRQ_EN_BIT];
				end
			end
		end
	end

	// ---------------- fast tick counter ----------------
	logic [4:0] ftw_cnt_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ftw_cnt_ff <= 5'h00;
			ftw_irq    <= 1'b0;
		end else begin
			ftw_irq <= 1'b0;
			if (!ftw_ctrl_ff[`CS_FTW_EN_BIT]) begin
				ftw_cnt_ff <= 5'h00;
			end else if (fast_tick) begin
				if (ftw_cnt_ff == ftw_ctrl_ff[`CS_FTW_TC_LSB +: 5]) begin
					ftw_cnt_ff <= 5'h00;
					ftw_irq    <= ftw_ctrl_ff[`CS_FTW_IRQ_EN_BIT];
				end else begin
					ftw_cnt_ff <= ftw_cnt_ff + 5'h01;
				end
			end
		end
	end

	// ---------------- watch crystal second pulse ----------------
	logic [15:0] rtc_cnt_ff;
	logic        watch_prev_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rtc_cnt_ff    <= 16'h0000;
			watch_prev_ff <= 1'b0;
			rtc_irq       <= 1'b0;
		end else begin
			watch_prev_ff <= watch_s;
			rtc_irq       <= 1'b0;
			if (watch_s && !watch_prev_ff) begin
				if (rtc_cnt_ff == 16'(RTC_EDGES - 1)) begin
					rtc_cnt_ff <= 16'h0000;
					rtc_irq    <= 1'b1;
				end else begin
					rtc_cnt_ff <= rtc_cnt_ff + 16'h0001;
				end
			end
		end
	end

	// ---------------- pll lock tracking ----------------
	clock_sources_pkg::lock_state_t lk_ff;
	logic [15:0] lk_cnt_ff;
	logic [1:0]  ref_prev_ff;
	logic        pll_on;

	assign pll_on = pll_ctrl_ff[`CS_PLL_EN_BIT] && pll_ctrl_ff[2:1] != 2'h3;

	// a reference change restarts the wait; the lock bit clears two cycles after the new reference is written
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lk_ff       <= clock_sources_pkg::LK_OFF;
			lk_cnt_ff   <= 16'h0000;
			ref_prev_ff <= 2'h0;
		end else begin
			ref_prev_ff <= pll_ctrl_ff[`CS_PLL_REF_LSB +: 2];
			if (!pll_on || ref_prev_ff != pll_ctrl_ff[`CS_PLL_REF_LSB +: 2]) begin
				lk_ff     <= clock_sources_pkg::LK_OFF;
				lk_cnt_ff <= 16'h0000;
			end else begin
				case (lk_ff)
					clock_sources_pkg::LK_OFF: begin
						lk_ff     <= clock_sources_pkg::LK_WAIT;
						lk_cnt_ff <= 16'h0000;
					end
					clock_sources_pkg::LK_WAIT: begin
						if (lk_cnt_ff == 16'(PLL_LOCK_CYC - 1)) begin
							lk_ff <= clock_sources_pkg::LK_LOCKED;
						end else begin
							lk_cnt_ff <= lk_cnt_ff + 16'h0001;
						end
					end
					clock_sources_pkg::LK_LOCKED: lk_ff <= clock_sources_pkg::LK_LOCKED;
					default: lk_ff <= clock_sources_pkg::LK_OFF;
				endcase
			end
		end
	end

	// ---------------- doubler startup ----------------
	logic [6:0] dbl_cnt_ff;
	logic [2:0] dbl_prev_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dbl_cnt_ff  <= 7'h00;
			dbl_prev_ff <= 3'h0;
			dbl_ready   <= 1'b0;
		end else begin
			dbl_prev_ff <= dbl_ctrl_ff[2:0];
			if (!dbl_ctrl_ff[`CS_DBL_EN_BIT] || dbl_ctrl_ff[2:1] == 2'h3
				|| dbl_prev_ff != dbl_ctrl_ff[2:0]) begin
				dbl_cnt_ff <= 7'h00;
				dbl_ready  <= 1'b0;
			end else if (dbl_cnt_ff == 7'(`CS_DBL_START_CYC - 1)) begin
				dbl_ready <= 1'b1;
			end else begin
				dbl_cnt_ff <= dbl_cnt_ff + 7'h01;
			end
		end
	end

	// ---------------- registered control outputs ----------------
	function automatic logic [7:0] trim_of(input logic [2:0] r);
		case (r)
			3'h0:    return 8'h40;
			3'h1:    return 8'h48;
			3'h2:    return 8'h50;
			3'h3:    return 8'h58;
			3'h4:    return 8'h60;
			3'h5:    return 8'h68;
			default: return 8'h40;
		endcase
	endfunction

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_range    <= 3'h0;
			osc_trim     <= 8'h40;
			osc_usb_mode <= 1'b0;
			sys_clk_sel  <= 3'h0;
			pll_enable   <= 1'b0;
			pll_ref_sel  <= 2'h0;
			pll_p        <= `CS_PLL_P_RST;
			pll_q        <= `CS_PLL_Q_RST;
			pll_lock     <= 1'b0;
			dbl_enable   <= 1'b0;
			dbl_src_sel  <= 2'h0;
		end else begin
			osc_range    <= osc_ctrl_ff[`CS_OSC_RANGE_LSB +: 3];
			osc_trim     <= trim_of(osc_ctrl_ff[`CS_OSC_RANGE_LSB +: 3]);
			osc_usb_mode <= osc_ctrl_ff[`CS_OSC_USB_BIT];
			sys_clk_sel  <= osc_ctrl_ff[`CS_OSC_SYS_LSB +: 3];
			pll_enable   <= pll_on;
			pll_ref_sel  <= pll_ctrl_ff[`CS_PLL_REF_LSB +: 2];
			pll_p        <= pll_ctrl_ff[`CS_PLL_P_LSB +: 8];
			pll_q        <= pll_ctrl_ff[`CS_PLL_Q_LSB +: 4];
			pll_lock     <= lk_ff == clock_sources_pkg::LK_LOCKED && pll_on;
			dbl_enable   <= dbl_ctrl_ff[`CS_DBL_EN_BIT];
			dbl_src_sel  <= dbl_ctrl_ff[`CS_DBL_SRC_LSB +: 2];
		end
	end

	// ---------------- read mux ----------------
	always_comb begin
		rd_ok  = 1'b1;
		rd_val = 32'h0000_0000;
		if (div_hit(araddr)) begin
			rd_val = div_cfg_ff[araddr[5:2]];
		end else begin
			case (araddr)
				`CS_CTC_CTRL_OFS:  rd_val = ctc_ctrl_ff;
				`CS_CTC_COUNT_OFS: rd_val = {19'h0, ctc_cnt_ff};
				`CS_FTW_CTRL_OFS:  rd_val = ftw_ctrl_ff | {11'h0, ftw_cnt_ff, 16'h0};
				`CS_PLL_CTRL_OFS:  rd_val = {pll_lock, pll_ctrl_ff[30:0]};
				`CS_DBL_CTRL_OFS:  rd_val = {dbl_ready, dbl_ctrl_ff[30:0]};
				`CS_OSC_CTRL_OFS:  rd_val = osc_ctrl_ff;
				default:           rd_ok  = 1'b0;
			endcase
		end
	end
endmodule

// File: verification/clock_sources_props.sv
`timescale 1ns/1ps
// pin-level watch on pll lock, low-speed clock rates and timer pulses
module clock_sources_props #(
	parameter int PLL_LOCK_CYC = 50
) (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       pll_enable,
	input wire logic [1:0] pll_ref_sel,
	input wire logic       pll_lock,
	input wire logic       ftw_irq,
	input wire logic       rtc_irq,
	input wire logic       fast_low_power_clock,
	input wire logic       third_rate_clock
);
	localparam int LOCK_MAX = PLL_LOCK_CYC + 4;
	logic [10:0] fc_ff;
	logic [10:0] tc_ff;
	logic        fs_ff;
	logic        ts_ff;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// level lengths; the level under way at reset release is partial, so skip it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fc_ff <= 11'h0;
			tc_ff <= 11'h0;
			fs_ff <= 1'b0;
			ts_ff <= 1'b0;
		end else begin
			fc_ff <= $changed(fast_low_power_clock) ? 11'h0 : fc_ff + 11'h1;
			tc_ff <= $changed(third_rate_clock) ? 11'h0 : tc_ff + 11'h1;
			fs_ff <= fs_ff | $changed(fast_low_power_clock);
			ts_ff <= ts_ff | $changed(third_rate_clock);
		end
	end
	lock_off_a: assert property (!pll_enable |=> !pll_lock)
		else $error("lock shown with pll off");
	ref_change_a: assert property ($changed(pll_ref_sel) |=> !pll_lock)
		else $error("lock kept over a reference change");
	lock_late_a: assert property ($rose(pll_enable) |-> !pll_lock [*8])
		else $error("lock shown before lock time");
	lock_time_a: assert property ($rose(pll_enable) |-> ##[1:LOCK_MAX] (pll_lock || !pll_enable))
		else $error("lock late");
	ftw_pulse_a: assert property (ftw_irq |=> !ftw_irq [*8])
		else $error("fast timer pulses too close");
	rtc_pulse_a: assert property (rtc_irq |=> !rtc_irq [*8])
		else $error("rtc pulses too close");
	flp_half_a: assert property (fs_ff && $changed(fast_low_power_clock) |-> fc_ff == 11'h1f3)
		else $error("fast clock half period wrong");
	third_half_a: assert property (ts_ff && $changed(third_rate_clock) |-> tc_ff == 11'h5db)
		else $error("third rate half period wrong");
endmodule

bind clock_sources clock_sources_props #(.PLL_LOCK_CYC(PLL_LOCK_CYC)) u_props (
	.aclk, .aresetn, .pll_enable, .pll_ref_sel, .pll_lock, .ftw_irq, .rtc_irq,
	.fast_low_power_clock, .third_rate_clock
);

// File: verification/clock_feed.sv
`timescale 1ns/1ps
// far-side sources: watch crystal pin and routed divider inputs
module clock_feed (
	input  wire logic  aclk,
	output logic       watch_crystal_osc,
	output logic [7:0] div_sources
);
	logic [15:0] cnt;
	initial begin
		cnt = 16'h0;
		watch_crystal_osc = 1'b0;
		div_sources = 8'h0;
	end
	// levels stay long so the pin synchronisers never miss one
	always @(posedge aclk) begin
		cnt <= cnt + 16'h1;
		watch_crystal_osc <= cnt[3];
		div_sources <= cnt[11:4];
	end
endmodule

// File: verification/tb_top.sv
`timescale 1ns/1ps
// drives registers and pins, times the timer and divider outputs
module tb_top;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, hibernate, debug_halt;
	logic        watch_crystal_osc, ftw_irq, rtc_irq, osc_usb_mode;
	logic [7:0]  awaddr, araddr, div_sources;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	logic [2:0]  osc_range, sys_clk_sel;
	logic [12:0] div_clk;
	int          err_total, n_tests, n;

	clock_sources #(.PLL_LOCK_CYC(50), .RTC_EDGES(8)) u_dut (
		.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .hibernate, .debug_halt, .watch_crystal_osc, .div_sources,
		.fast_low_power_clock(), .third_rate_clock(), .slow_tick_clock(), .ctc_wake(),
		.ctc_irq(), .ftw_irq, .rtc_irq, .osc_range, .osc_trim(), .osc_usb_mode,
		.sys_clk_sel, .pll_enable(), .pll_ref_sel(), .pll_p(), .pll_q(), .pll_lock(),
		.dbl_enable(), .dbl_src_sel(), .dbl_ready(), .div_clk
	);
	clock_feed u_feed (.aclk, .watch_crystal_osc, .div_sources);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	// address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	// cycles from one pulse to the next, rtc when sel is high
	task automatic gap(input logic sel);
		do @(posedge aclk); while (!(sel ? rtc_irq : ftw_irq));
		n = 0;
		do begin @(posedge aclk); n++; end while (!(sel ? rtc_irq : ftw_irq));
	endtask
	// length of the next whole level of one divided clock
	task automatic half(input int i);
		logic v;
		@(posedge aclk);
		v = div_clk[i];
		do @(posedge aclk); while (div_clk[i] === v);
		v = div_clk[i];
		n = 0;
		do begin @(posedge aclk); n++; end while (div_clk[i] === v);
	endtask

	task automatic t_regs;
		rd(8'h00); chk(d, 32'h0000_00a0);
		rd(8'h08); chk(d, 32'h0000_001f);
		rd(8'h0c); chk(d, 32'h0000_0800);
		rd(8'h20); chk({r, d[29:0]}, 32'h8000_0000);
		wr(8'h20, 32'h1); chk({30'h0, r}, 32'h2);
		@(posedge aclk);
		hibernate <= 1'b1;
		wr(8'h00, 32'h8000_00a0); rd(8'h04); chk(d, 32'h0);
		@(posedge aclk);
		hibernate <= 1'b0;
	endtask
	task automatic t_timers;
		wr(8'h08, 32'h0000_0303);
		gap(1'b0); chk(n, 32'h0fa0);
		gap(1'b1); chk(n, 32'h0080);
	endtask
	task automatic t_pll;
		for (int i = 0; i < 3; i++) begin
			logic [31:0] p;
			p = {29'h100, i[1:0], 1'b1};
			wr(8'h0c, p); wr(8'h10, {29'h0, i[1:0], 1'b1});
			rd(8'h0c); chk(d, p);
			repeat (110) @(posedge aclk);
			rd(8'h0c); chk(d, p | 32'h8000_0000);
			rd(8'h10); chk(d, {1'b1, 28'h0, i[1:0], 1'b1});
		end
		wr(8'h0c, 32'h0000_0301); rd(8'h0c); chk(d, 32'h8000_0805);
		wr(8'h0c, 32'h0000_0800); rd(8'h0c); chk(d, 32'h0000_0800);
	endtask
	task automatic t_osc;
		for (int i = 0; i < 7; i++) begin
			wr(8'h14, {25'h0, clock_sources_pkg::SYS_FLP, 1'b1, i[2:0]});
			repeat (2) @(posedge aclk);
			chk({osc_usb_mode, sys_clk_sel, osc_range}, {25'h0, 4'hc, i < 6 ? i[2:0] : 3'h5});
		end
	endtask
	task automatic t_div;
		wr(8'h70, 32'h8000_0003); half(12); half(12); chk(n, 32'h30);
		wr(8'h40, 32'h8001_0002); half(0); half(0); chk(n, 32'h40);
	endtask

	task end_sim;
		$display("Comparisons %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// generous limit: the whole sequence needs well under 20000 cycles
	initial begin
		repeat (60000) @(posedge aclk);
		err_total++;
		end_sim;
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, hibernate, debug_halt} = 8'h0;
		{awaddr, araddr, wdata} = 48'h0;
		wstrb = 4'hf;
		err_total = 0;
		n_tests = 0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs;
		t_timers;
		t_pll;
		t_osc;
		t_div;
		end_sim;
	end
endmodule
